// file: verilog/pfc_pkg.sv
package pfc_pkg;
    // Variant selector: decade (divide-by-five section) or binary (divide-by-eight)
    localparam logic VARIANT_DECADE = 1'b1;
    localparam logic VARIANT_BINARY = 1'b0;
    localparam int CNT_WIDTH = 4;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [2:0] QUINARY_LAST = 3'h4;
    localparam logic [2:0] OCTAL_LAST = 3'h7;
    localparam int SYNC_STAGES = 3;
    // Strobe and clear bits idle high; clock bits low
    localparam logic [7:0] SYNC_RESET = 8'h0c;
endpackage

// file: verilog/pfc_pin_sync.sv
`timescale 1ns/100ps
// Three-stage pin synchroniser; a change counts once stages two and three agree
module pfc_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
    logic [WIDTH-1:0] out_next;

    always_comb begin
        out_next = out_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                out_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            out_reg <= INIT;
        end else begin
            s1_reg <= pinIn;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign pinOut = out_reg;
endmodule // pfc_pin_sync

// file: verilog/pfc_counter.sv
`timescale 1ns/100ps
// Function
// - Decade variant counts BCD zero to nine
// - Separate divide-by-two and divide-by-five stages
// - Bi-quinary gives square wave at tenth rate
// - Binary variant divides by two, eight, sixteen
// - Low strobe loads data onto outputs
// - Low clear forces all outputs zero
// - Stages advance on falling clock edge only
module pfc_counter
    import pfc_pkg::*;
#(
    parameter logic VARIANT = VARIANT_DECADE
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clkFirstPin,
    input wire logic clkSecondPin,
    input wire logic strobeNPin,
    input wire logic clearNPin,
    input wire logic [3:0] dataPin,
    output logic [3:0] countOut
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; strobe and clear inactive (high) at reset
    // Bit map: clock A, clock B..D, strobe, clear, then data
    // Data rides the same filter, so a load only sees a word once it is stable
    logic [7:0] pinsIn, pinsSync;
    assign pinsIn = {dataPin, clearNPin, strobeNPin, clkSecondPin, clkFirstPin};

    pfc_pin_sync #(.WIDTH(8), .INIT(SYNC_RESET)) uSync (
        .mclk(mclk),
        .rst(rst),
        .pinIn(pinsIn),
        .pinOut(pinsSync)
    );

    logic clkFirst, clkSecond, strobeN, clearN;
    logic [3:0] dataIn;
    assign clkFirst = pinsSync[0];
    assign clkSecond = pinsSync[1];
    assign strobeN = pinsSync[2];
    assign clearN = pinsSync[3];
    assign dataIn = pinsSync[7:4];

    ////////////////////////////////////////////////////////////////////////
    // Falling-edge detect on the filtered clocks
    // History resets to the synchroniser's own level, so the first settle
    // after reset can only look like a rising edge, which never counts
    logic clkFirstPrev_reg, clkSecondPrev_reg;
    logic clkFirstPrev_next, clkSecondPrev_next;
    logic fallFirst, fallSecond;
    assign fallFirst = clkFirstPrev_reg & ~clkFirst;
    assign fallSecond = clkSecondPrev_reg & ~clkSecond;

    always_comb begin
        clkFirstPrev_next = clkFirst;
        clkSecondPrev_next = clkSecond;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clkFirstPrev_reg <= SYNC_RESET[0];
            clkSecondPrev_reg <= SYNC_RESET[1];
        end else begin
            clkFirstPrev_reg <= clkFirstPrev_next;
            clkSecondPrev_reg <= clkSecondPrev_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stage A is the lone binary; bits D..B form the upper section
    logic bitA_reg, bitA_next;
    logic [2:0] upper_reg, upper_next;

    function automatic logic [2:0] upperStep(input logic [2:0] v);
        logic [2:0] lastVal;
        lastVal = (VARIANT == VARIANT_DECADE) ? QUINARY_LAST : OCTAL_LAST;
        // Codes above the last one wrap too, so a bad preset recovers
        if (v >= lastVal) begin
            upperStep = 3'h0;
        end else begin
            upperStep = v + 3'h1;
        end
    endfunction

    always_comb begin
        bitA_next = bitA_reg;
        upper_next = upper_reg;
        // Clear outranks strobe, and both outrank counting
        if (!clearN) begin
            bitA_next = 1'b0;
            upper_next = 3'h0;
        end else if (!strobeN) begin
            bitA_next = dataIn[0];
            upper_next = dataIn[3:1];
        end else begin
            if (fallFirst) begin
                bitA_next = ~bitA_reg;
            end
            if (fallSecond) begin
                upper_next = upperStep(upper_reg);
            end
        end
    end

    // Registers only; every decision is made in the block above
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bitA_reg <= CNT_RESET[0];
            upper_reg <= CNT_RESET[3:1];
        end else begin
            bitA_reg <= bitA_next;
            upper_reg <= upper_next;
        end
    end

    // Decade upper section holds 0..4 and sits at weights 2,4,8 only in BCD wiring
    // Bits B..D carry the quinary value directly; output ordering matches packaging
    assign countOut = {upper_reg, bitA_reg};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_clear_zeroes: assert property (@(posedge mclk) disable iff (rst)
        !clearN |=> countOut == 4'h0)
        else $error("clear did not zero outputs");

    a_clear_priority: assert property (@(posedge mclk) disable iff (rst)
        (!clearN && !strobeN) |=> countOut == 4'h0)
        else $error("strobe overrode clear");

    a_strobe_load: assert property (@(posedge mclk) disable iff (rst)
        (clearN && !strobeN) |=> countOut == $past(dataIn))
        else $error("strobe did not load data");

    a_rise_holds: assert property (@(posedge mclk) disable iff (rst)
        (clearN && strobeN && !fallFirst && !fallSecond) |=> $stable(countOut))
        else $error("count moved without falling edge");

    a_a_toggle: assert property (@(posedge mclk) disable iff (rst)
        (clearN && strobeN && fallFirst) |=> bitA_reg != $past(bitA_reg))
        else $error("first stage did not toggle");

    sequence upperWrap;
        clearN && strobeN && fallSecond && upper_reg == ((VARIANT == VARIANT_DECADE) ? QUINARY_LAST : OCTAL_LAST);
    endsequence
    a_upper_wrap: assert property (@(posedge mclk) disable iff (rst)
        upperWrap |=> upper_reg == 3'h0)
        else $error("upper section did not wrap");

    a_upper_step: assert property (@(posedge mclk) disable iff (rst)
        (clearN && strobeN && fallSecond && upper_reg < QUINARY_LAST) |=> upper_reg == $past(upper_reg) + 3'h1)
        else $error("upper section did not step");

    a_upper_range: assert property (@(posedge mclk) disable iff (rst)
        (VARIANT == VARIANT_DECADE && clearN && strobeN && $past(clearN) && $past(strobeN)
         && $past(upper_reg) <= QUINARY_LAST) |-> upper_reg <= QUINARY_LAST)
        else $error("quinary section left its range");

    // Decade output read as a number stays a decimal digit once it is one
    a_decimal_range: assert property (@(posedge mclk) disable iff (rst)
        (VARIANT == VARIANT_DECADE && clearN && strobeN && $past(clearN) && $past(strobeN)
         && $past(countOut) <= 4'h9) |-> countOut <= 4'h9)
        else $error("decade output left decimal range");

    ////////////////////////////////////////////////////////////////////////
    // Edge direction and stage independence
    // Rising edges reach the detector but must leave both stages alone
    sequence firstRise;
        clearN && strobeN && !clkFirstPrev_reg && clkFirst;
    endsequence
    a_first_rise_ignored: assert property (@(posedge mclk) disable iff (rst)
        firstRise |=> bitA_reg == $past(bitA_reg))
        else $error("first stage moved on a rising edge");

    sequence secondRise;
        clearN && strobeN && !clkSecondPrev_reg && clkSecond;
    endsequence
    a_second_rise_ignored: assert property (@(posedge mclk) disable iff (rst)
        secondRise |=> upper_reg == $past(upper_reg))
        else $error("upper section moved on a rising edge");

    // Each stage answers only its own clock, so the two can be used apart
    sequence firstAlone;
        clearN && strobeN && fallFirst && !fallSecond;
    endsequence
    a_upper_independent: assert property (@(posedge mclk) disable iff (rst)
        firstAlone |=> upper_reg == $past(upper_reg))
        else $error("upper section followed the first clock");

    sequence secondAlone;
        clearN && strobeN && fallSecond && !fallFirst;
    endsequence
    a_first_independent: assert property (@(posedge mclk) disable iff (rst)
        secondAlone |=> bitA_reg == $past(bitA_reg))
        else $error("first stage followed the second clock");

    // Binary upper section runs the whole octal range before wrapping
    a_octal_step: assert property (@(posedge mclk) disable iff (rst)
        (VARIANT == VARIANT_BINARY && clearN && strobeN && fallSecond && upper_reg < OCTAL_LAST)
        |=> upper_reg == $past(upper_reg) + 3'h1)
        else $error("octal section did not step");

    // A held strobe or clear swallows clock edges; clear outranks strobe
    sequence loadWithEdge;
        clearN && !strobeN && (fallFirst || fallSecond);
    endsequence
    a_strobe_blocks: assert property (@(posedge mclk) disable iff (rst)
        loadWithEdge |=> countOut == $past(dataIn))
        else $error("count advanced during strobe");

    sequence clearWithEdge;
        !clearN && (fallFirst || fallSecond);
    endsequence
    a_clear_blocks: assert property (@(posedge mclk) disable iff (rst)
        clearWithEdge |=> countOut == 4'h0)
        else $error("count advanced during clear");

    // Level-sensitive load keeps tracking data while strobe stays low
    sequence loadSteady;
        clearN && !strobeN && $past(clearN) && !$past(strobeN) && $stable(dataIn);
    endsequence
    a_load_tracks: assert property (@(posedge mclk) disable iff (rst)
        loadSteady |-> countOut == dataIn)
        else $error("held strobe did not track data");
endmodule // pfc_counter

// file: bench/pfc_clk_src.sv
`timescale 1ns/100ps
// Far-side pulse source; each level held 8 mclk, well above the 2-cycle minimum
module pfc_clk_src (
    input wire logic mclk,
    output logic pulseOut
);
    initial pulseOut = 1'b1;
    // Falling half on its own, so the bench can look before the rise
    task automatic fall();
        @(negedge mclk);
        pulseOut = 1'b0;
        repeat (8) @(negedge mclk);
    endtask
    // Long high phase lets the ripple into the upper section settle
    task automatic rise();
        pulseOut = 1'b1;
        repeat (8) @(negedge mclk);
    endtask
    task automatic pulse();
        fall();
        rise();
    endtask
endmodule // pfc_clk_src

// file: bench/tb_presettable_four_bit_counter.sv
`timescale 1ns/100ps
module tb_presettable_four_bit_counter;
    import pfc_pkg::*;
    logic mclk, rst, strobeN, clearN, biQuin, pulse;
    logic [3:0] data, decOut, binOut;
    int errTotal, cmpCount;
    pfc_clk_src i_src (.mclk(mclk), .pulseOut(pulse));
    // Bench does the external wiring: BCD or bi-quinary chaining
    pfc_counter #(.VARIANT(VARIANT_DECADE)) i_dut (.mclk(mclk), .rst(rst),
        .clkFirstPin(biQuin ? decOut[3] : pulse), .clkSecondPin(biQuin ? pulse : decOut[0]),
        .strobeNPin(strobeN), .clearNPin(clearN), .dataPin(data), .countOut(decOut));
    pfc_counter #(.VARIANT(VARIANT_BINARY)) i_bin (.mclk(mclk), .rst(rst),
        .clkFirstPin(pulse), .clkSecondPin(binOut[0]),
        .strobeNPin(strobeN), .clearNPin(clearN), .dataPin(data), .countOut(binOut));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (10) @(negedge mclk);
    endtask
    task automatic finalReport();
        if (errTotal == 0 && cmpCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic testLoad();
        data = 4'h9;
        strobeN = 1'b0;
        settle();
        check(decOut, 4'h9);
        check(binOut, 4'h9);
        // Strobe is a level: new data under a held strobe must come through
        data = 4'h6;
        settle();
        check(decOut, 4'h6);
        check(binOut, 4'h6);
        i_src.pulse();
        check(decOut, 4'h6);
        check(binOut, 4'h6);
        clearN = 1'b0;
        settle();
        check(decOut, 4'h0);
        check(binOut, 4'h0);
        strobeN = 1'b1;
        clearN = 1'b1;
        settle();
    endtask
    // Mid-run reset over a nonzero count
    task automatic testReset();
        data = 4'h5;
        strobeN = 1'b0;
        settle();
        strobeN = 1'b1;
        settle();
        check(decOut, 4'h5);
        check(binOut, 4'h5);
        rst = 1'b1;
        @(negedge mclk);
        check(decOut, CNT_RESET);
        check(binOut, CNT_RESET);
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        settle();
        check(decOut, CNT_RESET);
        check(binOut, CNT_RESET);
    endtask
    // Mid-pulse look catches a count on the wrong edge, the full look a double count
    task automatic testCount();
        for (int i = 1; i <= 17; i++) begin
            i_src.fall();
            check({3'h0, decOut[0]}, 4'(i % 2));
            check({3'h0, binOut[0]}, 4'(i % 2));
            i_src.rise();
            check(decOut, 4'(i % 10));
            check(binOut, 4'(i % 16));
        end
    endtask
    task automatic testBiQuin();
        clearN = 1'b0;
        settle();
        biQuin = 1'b1;
        settle();
        clearN = 1'b1;
        settle();
        for (int i = 1; i <= 10; i++) begin
            i_src.pulse();
            check({3'h0, decOut[0]}, 4'((i / 5) % 2));
            check({1'b0, decOut[3:1]}, 4'(i % 5));
        end
    endtask
    initial begin
        rst = 1'b1;
        strobeN = 1'b1;
        clearN = 1'b1;
        data = 4'h0;
        biQuin = 1'b0;
        errTotal = 0;
        cmpCount = 0;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        settle();
        check(decOut, CNT_RESET);
        check(binOut, CNT_RESET);
        testLoad();
        testReset();
        testCount();
        testBiQuin();
        finalReport();
    end
endmodule // tb_presettable_four_bit_counter
